// File: pkg/cglcd_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef CGLCD_PARAMS_SVH
`define CGLCD_PARAMS_SVH

// io port addresses, ten bits
`define CGLCD_PORT_INDEX 10'h3d4
`define CGLCD_PORT_DATA 10'h3d5
`define CGLCD_PORT_MODE_A 10'h3d8
`define CGLCD_PORT_STATUS 10'h3da
`define CGLCD_PORT_MODE_B 10'h3de
// index/data pair group: 3d0..3d7
`define CGLCD_PAIR_BASE 7'h7a

// indexed registers
`define CGLCD_IDX_CFG 8'h07
`define CGLCD_IDX_PANEL_MODE 8'hcc
`define CGLCD_IDX_OVERLAY 8'hcd
`define CGLCD_IDX_CRT_LO 8'h01
`define CGLCD_IDX_CRT_HI 8'h09

// field positions
`define CGLCD_PM_DLY_LSB 3
`define CGLCD_PM_TALL 2
`define CGLCD_PM_STYLE1 1
`define CGLCD_PM_STYLE2 0
`define CGLCD_OV_EN 7
`define CGLCD_MA_BLINK 5
`define CGLCD_MA_GRAPHICS_RES_LOW_SEL 4
`define CGLCD_MA_VIDEO_ON_HINT 3
`define CGLCD_MA_GRAPHICS_MODE_SELECT 1
`define CGLCD_MA_TEXT_COLUMN_SELECT 0
`define CGLCD_MB_UNDRL 6
`define CGLCD_MB_PAGE 3
`define CGLCD_MB_GRAPHICS_RES_HIGH_SEL 0
`define CGLCD_CFG_CYC_LSB 5

// reset values
`define CGLCD_RST_REG 8'h00
// status reserved bits: d7..d4 = f, d2 = 1
`define CGLCD_STATUS_FILL 8'hf4
`define CGLCD_UNDEF_READ 8'hff

// timing: shortest sequencing step 7.5 ms = 7500 us at 50 MHz
`define CGLCD_STEP_US 7500
`define CGLCD_CLK_MHZ 50
`define CGLCD_STEP_CYCLES (`CGLCD_STEP_US * `CGLCD_CLK_MHZ)
// simulated retrace: line lengths in system clocks, frame lengths in lines
`define CGLCD_LINE_CYCLES 3200
`define CGLCD_HRET_CYCLES 400
`define CGLCD_FRAME_LINES 262
`define CGLCD_VRET_LINES 22
// load clock pulse widths in system clocks
`define CGLCD_LOAD_GENERIC 6
`define CGLCD_LOAD_STYLE1 10
`define CGLCD_LOAD_STYLE2 5

`endif

// File: pkg/cglcd_pkg.sv
// types shared by the lcd mode control block
package cglcd_pkg;
    typedef enum logic [2:0] {
        CGLCD_TEXT40, CGLCD_TEXT80, CGLCD_G320, CGLCD_G640, CGLCD_G640X400
    } cglcd_mode_t;
    typedef enum logic [1:0] {
        CGLCD_MIX_MOD, CGLCD_MIX_OR, CGLCD_MIX_XOR, CGLCD_MIX_RSV
    } cglcd_mix_t;
    typedef enum logic [1:0] {
        CGLCD_CYC_FAST, CGLCD_CYC_NORMAL, CGLCD_CYC_SLOW, CGLCD_CYC_RSV
    } cglcd_cyc_t;
endpackage

// File: design/cglcd_mode_control.sv
// lcd mode control: io decode, mode registers, overlay, memory strobes
`timescale 1ns/1ps
`include "cglcd_params.svh"

module cglcd_mode_control (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [9:0] ioAddr,
    input wire logic aen,
    input wire logic ioRd_n,
    input wire logic ioWr_n,
    input wire logic [7:0] ioDataIn,
    output logic [7:0] ioDataOut,
    output logic ioDataOe,
    input wire logic powerStepReq,
    output logic powerStepDone,
    input wire logic [3:0] upperHalfData,
    input wire logic [3:0] lowerHalfData,
    output logic [3:0] upper_panel_data,
    output logic line_load_clock,
    output logic video_on_hint,
    output logic attrTopIsBlink,
    output logic underlineOn,
    output logic grayscaleOn,
    output logic display_page_select,
    output logic singleTextPage,
    output cglcd_pkg::cglcd_mode_t displayMode,
    output logic tall_panel_select,
    input wire logic memCycleReq,
    input wire logic memWordWide,
    output logic memCs_n,
    output logic memOe_n,
    output logic memCycleBusy
);

    // three-flop sampling of the pin-side io strobes
    logic [2:0] rdSync;
    logic [2:0] wrSync;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdSync <= 3'h7;
            wrSync <= 3'h7;
        end else begin
            rdSync <= {rdSync[1:0], ioRd_n};
            wrSync <= {wrSync[1:0], ioWr_n};
        end
    end

    // a strobe counts only once stages two and three agree
    logic rdLevel;
    logic wrLevel;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdLevel <= 1'b0;
            wrLevel <= 1'b0;
        end else begin
            if (rdSync[1] == rdSync[2]) begin
                rdLevel <= ~rdSync[2];
            end
            if (wrSync[1] == wrSync[2]) begin
                wrLevel <= ~wrSync[2];
            end
        end
    end

    // port decode: address and aen are held stable through the strobe
    wire selHit = !aen;
    wire [9:0] port = ioAddr[9:0];
    wire pairHit = selHit && (port[9:3] == `CGLCD_PAIR_BASE);
    wire idxHit = pairHit && !port[0];
    wire datHit = pairHit && port[0];
    wire modeAHit = selHit && (port == `CGLCD_PORT_MODE_A);
    wire statHit = selHit && (port == `CGLCD_PORT_STATUS);
    wire modeBHit = selHit && (port == `CGLCD_PORT_MODE_B);
    wire anyHit = pairHit || modeAHit || statHit || modeBHit;

    logic wrLevelQ;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wrLevelQ <= 1'b0;
        end else begin
            wrLevelQ <= wrLevel;
        end
    end
    // a write is taken once, at its rising level edge
    wire wrPulse = wrLevel && !wrLevelQ;

    logic [7:0] crtIndex;
    logic [7:0] modeA;
    logic [7:0] modeB;
    logic [7:0] panelMode;
    logic [7:0] overlay;
    logic [7:0] cfgReg;

    // writes: index, direct mode ports, indexed registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            crtIndex <= `CGLCD_RST_REG;
            modeA <= `CGLCD_RST_REG;
            modeB <= `CGLCD_RST_REG;
            panelMode <= `CGLCD_RST_REG;
            overlay <= `CGLCD_RST_REG;
            cfgReg <= `CGLCD_RST_REG;
        end else if (wrPulse) begin
            if (idxHit) begin
                crtIndex <= ioDataIn;
            end
            if (modeAHit) begin
                modeA <= ioDataIn;
            end
            if (modeBHit) begin
                modeB <= ioDataIn;
            end
            if (datHit) begin
                // indices other than 07, cc and cd fall through unstored
                unique case (crtIndex)
                    `CGLCD_IDX_PANEL_MODE: panelMode <= ioDataIn;
                    `CGLCD_IDX_OVERLAY: overlay <= ioDataIn;
                    `CGLCD_IDX_CFG: cfgReg <= ioDataIn;
                    default: ;
                endcase
            end
        end
    end

    // indexed read: unimplemented indices return all ones
    logic [7:0] idxRead;
    always_comb begin
        unique case (crtIndex)
            `CGLCD_IDX_PANEL_MODE: idxRead = panelMode;
            `CGLCD_IDX_OVERLAY: idxRead = overlay;
            `CGLCD_IDX_CFG: idxRead = cfgReg;
            default: idxRead = `CGLCD_UNDEF_READ;
        endcase
    end

    logic hRetrace;
    logic vRetrace;
    wire [7:0] statusVal = `CGLCD_STATUS_FILL
        | {4'h0, vRetrace, 2'h0, hRetrace};
    wire [7:0] readMux = idxHit ? crtIndex :
        datHit ? idxRead :
        modeAHit ? modeA :
        modeBHit ? modeB : statusVal;

    // read data is registered so the output comes from a flop
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ioDataOut <= 8'h00;
            ioDataOe <= 1'b0;
        end else begin
            ioDataOut <= readMux;
            ioDataOe <= rdLevel && anyHit;
        end
    end

    // simulated retrace from free counters; no real crt timing behind it
    logic [11:0] pixCnt;
    logic [8:0] lineCnt;
    wire lineEnd = (pixCnt == 12'(`CGLCD_LINE_CYCLES - 1));
    wire frameEnd = (lineCnt == 9'(`CGLCD_FRAME_LINES - 1));
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pixCnt <= 12'h000;
            lineCnt <= 9'h000;
        end else begin
            pixCnt <= lineEnd ? 12'h000 : pixCnt + 12'h001;
            if (lineEnd) begin
                lineCnt <= frameEnd ? 9'h000 : lineCnt + 9'h001;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hRetrace <= 1'b0;
            vRetrace <= 1'b0;
        end else begin
            hRetrace <= pixCnt >= 12'(`CGLCD_LINE_CYCLES
                - `CGLCD_HRET_CYCLES);
            vRetrace <= lineCnt >= 9'(`CGLCD_FRAME_LINES
                - `CGLCD_VRET_LINES);
        end
    end

    // mode decode
    function automatic cglcd_pkg::cglcd_mode_t decodeMode(
        input logic [7:0] a,
        input logic [7:0] b
    );
        if (!a[`CGLCD_MA_GRAPHICS_MODE_SELECT]) begin
            decodeMode = a[`CGLCD_MA_TEXT_COLUMN_SELECT] ? cglcd_pkg::CGLCD_TEXT80
                : cglcd_pkg::CGLCD_TEXT40;
        end else if (!a[`CGLCD_MA_GRAPHICS_RES_LOW_SEL]) begin
            decodeMode = cglcd_pkg::CGLCD_G320;
        end else begin
            decodeMode = b[`CGLCD_MB_GRAPHICS_RES_HIGH_SEL] ? cglcd_pkg::CGLCD_G640X400
                : cglcd_pkg::CGLCD_G640;
        end
    endfunction
    wire cglcd_pkg::cglcd_mode_t next_displayMode =
        decodeMode(modeA, modeB);

    // mode outputs, all registered
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            displayMode <= cglcd_pkg::CGLCD_TEXT40;
            attrTopIsBlink <= 1'b0;
            video_on_hint <= 1'b0;
            underlineOn <= 1'b0;
            grayscaleOn <= 1'b1;
            display_page_select <= 1'b0;
            singleTextPage <= 1'b0;
            tall_panel_select <= 1'b0;
        end else begin
            displayMode <= next_displayMode;
            attrTopIsBlink <= modeA[`CGLCD_MA_BLINK];
            video_on_hint <= modeA[`CGLCD_MA_VIDEO_ON_HINT];
            underlineOn <= modeB[`CGLCD_MB_UNDRL];
            grayscaleOn <= !modeB[`CGLCD_MB_UNDRL];
            display_page_select <= modeB[`CGLCD_MB_PAGE];
            singleTextPage <= modeB[`CGLCD_MB_GRAPHICS_RES_HIGH_SEL];
            tall_panel_select <= panelMode[`CGLCD_PM_TALL];
        end
    end

    // overlay combine; reserved code passes upper data unchanged
    wire cglcd_pkg::cglcd_mix_t mixSel =
        cglcd_pkg::cglcd_mix_t'(overlay[1:0]);
    logic [3:0] mixed;
    always_comb begin
        unique case (mixSel)
            cglcd_pkg::CGLCD_MIX_MOD: mixed = upperHalfData & ~lowerHalfData;
            cglcd_pkg::CGLCD_MIX_OR: mixed = upperHalfData | lowerHalfData;
            cglcd_pkg::CGLCD_MIX_XOR: mixed = upperHalfData ^ lowerHalfData;
            cglcd_pkg::CGLCD_MIX_RSV: mixed = upperHalfData;
        endcase
    end
    wire inkOn = overlay[`CGLCD_OV_EN] && panelMode[`CGLCD_PM_TALL];
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            upper_panel_data <= 4'h0;
        end else begin
            upper_panel_data <= inkOn ? mixed : upperHalfData;
        end
    end

    // load clock: one pulse per simulated line, width set by style
    wire [3:0] loadWidth = panelMode[`CGLCD_PM_STYLE1] ?
        4'(`CGLCD_LOAD_STYLE1) : panelMode[`CGLCD_PM_STYLE2] ?
        4'(`CGLCD_LOAD_STYLE2) : 4'(`CGLCD_LOAD_GENERIC);
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            line_load_clock <= 1'b0;
        end else begin
            line_load_clock <= pixCnt < {8'h00, loadWidth};
        end
    end

    // power step delay: base step doubled per code, codes 6 and 7 start no step
    wire [2:0] dlySel = panelMode[`CGLCD_PM_DLY_LSB +: 3];
    logic [27:0] stepCnt;
    logic stepRun;
    wire [27:0] stepLen = 28'(`CGLCD_STEP_CYCLES) << dlySel;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stepCnt <= 28'h0000000;
            stepRun <= 1'b0;
            powerStepDone <= 1'b0;
        end else begin
            powerStepDone <= 1'b0;
            if (!stepRun && powerStepReq && !(dlySel[2] && dlySel[1])) begin
                stepRun <= 1'b1;
                stepCnt <= 28'h0000000;
            end else if (stepRun) begin
                stepCnt <= stepCnt + 28'h0000001;
                if (stepCnt == stepLen - 28'h0000001) begin
                    stepRun <= 1'b0;
                    powerStepDone <= 1'b1;
                end
            end
        end
    end

    // memory cycle counted once per clock: cs active, then cs inactive
    wire cglcd_pkg::cglcd_cyc_t cycType =
        cglcd_pkg::cglcd_cyc_t'(cfgReg[`CGLCD_CFG_CYC_LSB +: 2]);
    logic [2:0] csOn;
    logic [2:0] csOff;
    always_comb begin
        unique case (cycType)
            cglcd_pkg::CGLCD_CYC_FAST: begin
                csOn = 3'h2;
                csOff = 3'h1;
            end
            cglcd_pkg::CGLCD_CYC_NORMAL: begin
                csOn = 3'h2;
                csOff = 3'h2;
            end
            default: begin
                csOn = 3'h3;
                csOff = 3'h2;
            end
        endcase
    end
    // word cycles hold select two clocks longer
    wire [3:0] onHalf = {csOn + 3'(memWordWide), 1'b0};
    wire [3:0] totHalf = onHalf + {csOff, 1'b0};
    // oe goes low one clock after cs and rises with it
    wire [3:0] oeStart = 4'h1;
    logic [3:0] halfCnt;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            halfCnt <= 4'h0;
            memCycleBusy <= 1'b0;
            memCs_n <= 1'b1;
            memOe_n <= 1'b1;
        end else begin
            if (!memCycleBusy) begin
                if (memCycleReq) begin
                    memCycleBusy <= 1'b1;
                    halfCnt <= 4'h0;
                    memCs_n <= 1'b0;
                end
            end else begin
                halfCnt <= halfCnt + 4'h1;
                memCs_n <= !(halfCnt + 4'h1 < onHalf);
                memOe_n <= !(halfCnt + 4'h1 >= oeStart
                    && halfCnt + 4'h1 < onHalf);
                if (halfCnt + 4'h1 == totHalf) begin
                    memCycleBusy <= 1'b0;
                    memCs_n <= 1'b1;
                    memOe_n <= 1'b1;
                end
            end
        end
    end

endmodule

// File: tb/cglcd_mode_control_chk.sv
// port-level assertions for the lcd mode control block
`timescale 1ns/1ps
module cglcd_mode_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [9:0] ioAddr,
    input wire logic aen,
    input wire logic ioRd_n,
    input wire logic ioDataOe,
    input wire logic powerStepDone,
    input wire logic [3:0] upperHalfData,
    input wire logic [3:0] upper_panel_data,
    input wire logic line_load_clock,
    input wire logic underlineOn,
    input wire logic grayscaleOn,
    input wire logic tall_panel_select,
    input wire logic memCycleReq,
    input wire logic memCs_n,
    input wire logic memOe_n,
    input wire logic memCycleBusy
);
    // single clock domain, so one default clocking and reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    a_read_decoded: assert property (
        $rose(ioDataOe) |-> !ioRd_n && !aen && ioAddr[9:4] == 6'h3d)
        else $error("read answered without a decoded strobe");
    a_underline_swap: assert property (
        grayscaleOn == !underlineOn)
        else $error("underline and grayscale not exclusive");
    a_load_width: assert property (
        $rose(line_load_clock) |-> line_load_clock[*5] ##[1:6]
        !line_load_clock)
        else $error("load clock width out of range");
    a_cs_low_span: assert property (
        $fell(memCs_n) |-> (!memCs_n)[*4] ##[1:5] memCs_n)
        else $error("chip select low time out of range");
    a_oe_inside_cs: assert property (
        !memOe_n |-> !memCs_n && memCycleBusy)
        else $error("output enable outside chip select");
    a_cycle_start: assert property (
        memCycleReq && !memCycleBusy |=> memCycleBusy && !memCs_n && memOe_n)
        else $error("memory cycle did not start");
    a_busy_span: assert property (
        $rose(memCycleBusy) |-> memCycleBusy[*6] ##[1:7] !memCycleBusy)
        else $error("memory cycle length out of range");
    a_done_pulse: assert property (
        powerStepDone |=> !powerStepDone)
        else $error("power step done longer than one cycle");
    // tall select and panel data are both one flop behind the mode bit
    a_overlay_bypass: assert property (
        $past(reset_n) && !tall_panel_select |->
        upper_panel_data == $past(upperHalfData))
        else $error("upper data altered without tall select");
endmodule

bind cglcd_mode_control cglcd_mode_chk i_chk (
    .clk_sys, .reset_n, .ioAddr, .aen, .ioRd_n, .ioDataOe, .powerStepDone,
    .upperHalfData, .upper_panel_data, .line_load_clock, .underlineOn,
    .grayscaleOn, .tall_panel_select, .memCycleReq, .memCs_n, .memOe_n,
    .memCycleBusy
);

// File: tb/cglcd_host_model.sv
// host processor model: xt-style io read and write cycles
`timescale 1ns/1ps
module cglcd_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] ioDataOut,
    input wire logic ioDataOe,
    output logic [9:0] ioAddr,
    output logic aen,
    output logic ioRd_n,
    output logic ioWr_n,
    output logic [7:0] ioDataIn
);
    // idle bus: strobes high, bus owned by nobody
    initial begin
        ioAddr = 10'h000;
        aen = 1'b1;
        ioRd_n = 1'b1;
        ioWr_n = 1'b1;
        ioDataIn = 8'h00;
    end
    // strobe low 7 clocks then high 7: beats the six-clock minimum
    task automatic io_cycle(input logic [9:0] a, input logic aenLvl,
        input logic wr, input logic [7:0] wd, output logic [7:0] rd,
        output logic hit);
        hit = 1'b0;
        rd = 8'h00;
        @(posedge clk_sys);
        #1;
        ioAddr = a;
        aen = aenLvl;
        ioDataIn = wd;
        ioWr_n = !wr;
        ioRd_n = wr;
        // look just after each edge so the registered answer has settled
        repeat (7) begin
            @(posedge clk_sys);
            #1;
            if (!hit && ioDataOe === 1'b1) begin
                hit = 1'b1;
                rd = ioDataOut;
            end
        end
        ioWr_n = 1'b1;
        ioRd_n = 1'b1;
        aen = 1'b1;
        // released lines flip so a stale value never looks live
        ioAddr = ~a;
        ioDataIn = ~wd;
        repeat (7) @(posedge clk_sys);
    endtask
endmodule

// File: tb/tb_cga_lcd_mode_control.sv
// self-checking bench for the lcd mode control block
`timescale 1ns/1ps
module tb_cga_lcd_mode_control;
    logic clk_sys, reset_n, aen, ioRd_n, ioWr_n, ioDataOe, hit;
    logic powerStepReq, powerStepDone, memCycleReq, memWordWide;
    logic line_load_clock, video_on_hint, attrTopIsBlink, underlineOn;
    logic grayscaleOn, display_page_select, singleTextPage;
    logic tall_panel_select, memCs_n, memOe_n, memCycleBusy;
    logic [9:0] ioAddr;
    logic [7:0] ioDataIn, ioDataOut, rd;
    logic [3:0] upperHalfData, lowerHalfData, upper_panel_data;
    cglcd_pkg::cglcd_mode_t displayMode;
    int bad_count = 0;
    int n_checks = 0;
    // strobe clocks, half-clock scaled to one: index type + 3 * word
    int csE[6] = '{4, 4, 6, 6, 6, 8};
    int oeE[6] = '{3, 3, 5, 5, 5, 7};
    int bzE[6] = '{6, 8, 10, 8, 10, 12};
    logic [7:0] mA[5] = '{8'h00, 8'h29, 8'h02, 8'h12, 8'h32};
    logic [7:0] mB[5] = '{8'h00, 8'h48, 8'h40, 8'h08, 8'h49};
    cglcd_pkg::cglcd_mode_t mE[5] = '{cglcd_pkg::CGLCD_TEXT40,
        cglcd_pkg::CGLCD_TEXT80, cglcd_pkg::CGLCD_G320,
        cglcd_pkg::CGLCD_G640, cglcd_pkg::CGLCD_G640X400};
    // upper c, lower a: modulate, or, xor, reserved
    logic [3:0] ovE[4] = '{4'h4, 4'he, 4'h6, 4'hc};

    cglcd_mode_control i_dut (
        .clk_sys, .reset_n, .ioAddr, .aen, .ioRd_n, .ioWr_n, .ioDataIn,
        .ioDataOut, .ioDataOe, .powerStepReq, .powerStepDone,
        .upperHalfData, .lowerHalfData, .upper_panel_data,
        .line_load_clock, .video_on_hint, .attrTopIsBlink, .underlineOn,
        .grayscaleOn, .display_page_select, .singleTextPage, .displayMode,
        .tall_panel_select, .memCycleReq, .memWordWide, .memCs_n,
        .memOe_n, .memCycleBusy
    );
    cglcd_host_model i_host (
        .clk_sys, .ioDataOut, .ioDataOe, .ioAddr, .aen, .ioRd_n, .ioWr_n,
        .ioDataIn
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input string s, input logic [7:0] e,
        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", s, e, g);
            bad_count++;
        end
    endtask
    task automatic chk1(input string s, input logic e, input logic g);
        chk(s, {7'h0, e}, {7'h0, g});
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        i_host.io_cycle(a, 1'b0, 1'b1, d, rd, hit);
    endtask
    task automatic rdx(input string s, input logic [9:0] a,
        input logic [7:0] e);
        i_host.io_cycle(a, 1'b0, 1'b0, 8'h00, rd, hit);
        chk1(s, 1'b1, hit);
        chk(s, e, rd);
    endtask
    // index then data: the pair always travels together
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        wr(10'h3d4, i);
        wr(10'h3d5, d);
    endtask
    // write then read that the decode has to ignore
    task automatic miss(input logic [9:0] a, input logic aenLvl);
        i_host.io_cycle(a, aenLvl, 1'b1, 8'h07, rd, hit);
        i_host.io_cycle(a, aenLvl, 1'b0, 8'h00, rd, hit);
        chk1("refused", 1'b0, hit);
    endtask
    task automatic loadw(input logic [7:0] pm, input int w);
        int n;
        n = 0;
        wreg(8'hcc, pm);
        @(posedge line_load_clock);
        while (line_load_clock === 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("load width", 8'(w), 8'(n));
    endtask
    // second request lands while busy and must be dropped
    task automatic memrun(input int t, input logic w);
        int cs, oe, bz, k;
        cs = 0;
        oe = 0;
        bz = 0;
        k = t + 3 * int'(w);
        wreg(8'h07, {1'b0, t[1:0], 5'h00});
        #1;
        memWordWide = w;
        memCycleReq = 1'b1;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            #1;
            if (i == 1)
                memCycleReq = 1'b0;
            cs += int'(memCs_n === 1'b0);
            oe += int'(memOe_n === 1'b0);
            bz += int'(memCycleBusy === 1'b1);
        end
        chk("cs low", 8'(csE[k]), 8'(cs));
        chk("oe low", 8'(oeE[k]), 8'(oe));
        chk("busy", 8'(bzE[k]), 8'(bz));
    endtask
    // a step never ends early, and a reserved code never starts one
    task automatic steprun(input logic [7:0] pm);
        int n;
        n = 0;
        wreg(8'hcc, pm);
        #1;
        powerStepReq = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        powerStepReq = 1'b0;
        repeat (200) begin
            @(posedge clk_sys);
            #1;
            n += int'(powerStepDone === 1'b1);
        end
        chk("step done", 8'h00, 8'(n));
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // the tests need well under half a millisecond
    initial begin
        #1_000_000;
        bad_count++;
        $display("[ERR] watchdog expected done seen hang");
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        powerStepReq = 1'b0;
        memCycleReq = 1'b0;
        memWordWide = 1'b0;
        upperHalfData = 4'hc;
        lowerHalfData = 4'ha;
        repeat (8) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        @(posedge clk_sys);
        #1;
        chk1("gray reset", 1'b1, grayscaleOn);
        chk1("cs reset", 1'b1, memCs_n);
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            wr(10'h3d0 + 10'(2 * k), 8'hcc);
            wr(10'h3d1 + 10'(2 * k), 8'h04 + 8'(k));
            rdx("index", 10'h3d0 + 10'(2 * k), 8'hcc);
            rdx("data", 10'h3d5, 8'h04 + 8'(k));
        end
        chk1("tall", 1'b1, tall_panel_select);
        loadw(8'h04, 6);
        loadw(8'h05, 5);
        loadw(8'h06, 10);
        $display("index and load test done");
        miss(10'h3d4, 1'b1);
        miss(10'h3d9, 1'b0);
        miss(10'h1d4, 1'b0);
        rdx("index kept", 10'h3d4, 8'hcc);
        wreg(8'h01, 8'h55);
        rdx("timing reg lo", 10'h3d5, 8'hff);
        wreg(8'h09, 8'h55);
        rdx("timing reg hi", 10'h3d5, 8'hff);
        $display("decode test done");
        for (int k = 0; k < 5; k++) begin
            wr(10'h3d8, mA[k]);
            wr(10'h3de, mB[k]);
            rdx("mode a", 10'h3d8, mA[k]);
            rdx("mode b", 10'h3de, mB[k]);
            chk("mode", {5'h0, mE[k]}, {5'h0, displayMode});
            chk1("blink", mA[k][5], attrTopIsBlink);
            chk1("video", mA[k][3], video_on_hint);
            chk1("underline", mB[k][6], underlineOn);
            chk1("gray", !mB[k][6], grayscaleOn);
            chk1("page", mB[k][3], display_page_select);
            chk1("single", mB[k][0], singleTextPage);
        end
        wr(10'h3da, 8'h00);
        // line start: no horizontal retrace, frame far from its end
        @(posedge line_load_clock);
        i_host.io_cycle(10'h3da, 1'b0, 1'b0, 8'h00, rd, hit);
        chk1("status hit", 1'b1, hit);
        chk("status", 8'hf4, rd);
        // late in the line the horizontal retrace bit is up
        repeat (2800) @(posedge clk_sys);
        rdx("status late", 10'h3da, 8'hf5);
        $display("mode test done");
        // tall select only for a 400-line panel
        wreg(8'hcc, 8'h04);
        for (int m = 0; m < 4; m++) begin
            wreg(8'hcd, 8'h80 | 8'(m));
            chk("overlay", {4'h0, ovE[m]}, {4'h0, upper_panel_data});
        end
        wreg(8'hcd, 8'h01);
        chk("overlay off", 8'h0c, {4'h0, upper_panel_data});
        $display("overlay test done");
        steprun(8'h34);
        steprun(8'h04);
        $display("power step test done");
        for (int t = 0; t < 3; t++) begin
            memrun(t, 1'b0);
            memrun(t, 1'b1);
        end
        $display("memory test done");
        report_and_stop();
    end
endmodule
